// >>> src/wwdt_pkg.sv
// Package with constants and types for the windowed watchdog timer.
package wwdt_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] CTRL_INDEX = 8'h00;
    localparam logic [7:0] STATE_INDEX = 8'h01;
    localparam logic [7:0] GUARD_INDEX = 8'h02;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(4 * CTRL_INDEX);
    localparam logic [ADDR_W-1:0] STATE_ADDR = ADDR_W'(4 * STATE_INDEX);
    localparam logic [ADDR_W-1:0] GUARD_ADDR = ADDR_W'(4 * GUARD_INDEX);

    // Field positions.
    localparam int PERIOD_LSB = 0;
    localparam int WINDOW_LSB = 4;
    localparam int LOCK_BIT = 7;
    localparam int SYNC_BIT = 0;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATE_RESET = 8'h00;

    // Select codes.
    localparam logic [3:0] SEL_OFF = 4'h0;
    localparam logic [3:0] SEL_MIN = 4'h1;
    localparam logic [3:0] SEL_MAX = 4'hb;
    localparam logic [13:0] SEL_BASE_CYCLES = 14'h0008;

    // Unlock key written to the change guard; the value is arbitrary.
    localparam logic [7:0] IO_UNLOCK_KEY = 8'h5a;
    // Number of following bus transfers for which the key stays valid.
    localparam logic [2:0] GUARD_WINDOW = 3'h4;

    // Watchdog clock and synchroniser depths in watchdog clock cycles.
    localparam longint CLK_HZ = 100_000_000;
    localparam longint OSC_HZ = 1_000;
    localparam int TICK_DIV = int'(CLK_HZ / OSC_HZ);
    localparam logic [1:0] SYNC_TICKS = 2'h3;

    // Control register layout.
    typedef struct packed {
        logic [3:0] window;
        logic [3:0] period;
    } wwdt_ctrl_t;

    // Counter states.
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_FIRST = 2'b01,
        ST_CLOSED = 2'b10,
        ST_OPEN = 2'b11
    } wwdt_state_t;

endpackage

// >>> src/wwdt_top.sv
// Windowed watchdog timer with APB registers, change guard and lock.
// Operation
// - Normal mode resets after unserviced time-out
// - Accepted clear restarts the counter
// - Period codes one to eleven enable the watchdog
// - Codes one to eleven select 8..8K cycles
// - Zero window code means normal mode
// - Window codes one to eleven select closed period length
// - Clear during closed period causes reset
// - Open period follows closed; late means reset
// - Closed period starts after first clear
// - Clear sync takes 2-3 ticks, extras ignored
// - Control writes synchronise; pending flag shows it
// - Lock makes control read-only; debug clears
// - Non-zero boot period sets lock automatically
// - Protected writes need key within four accesses
// - Unkeyed protected write is silently dropped
// - Pending flag is read-only and unguarded
// - Watchdog keeps running in sleep modes
// - Control reset value comes from boot fuse
// - Debug halt resets the watchdog counter
// - Counter runs from the 1 kHz tick
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps

module wwdt_top #(
    parameter int TICK_DIV = wwdt_pkg::TICK_DIV
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wwdt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor core.
    input wire logic watchdog_clear_instr,
    input wire logic debug_halt,
    // Boot configuration.
    input wire logic [7:0] boot_fuse_config,
    // Reset controller.
    output logic sys_reset_req
);

    // The divider must hold TICK_DIV - 1, so its width follows the parameter.
    // A small TICK_DIV in simulation keeps the short time-outs to a few hundred clocks,
    // while the default gives the true 1 kHz watchdog rate at 100 MHz.
    localparam int DIV_W = $clog2(TICK_DIV + 1);

    // Decode a select code into a cycle count; reserved and off give zero.
    // The same decode serves the open and the closed period, so it is one function.
    // Treating reserved codes as zero means a reserved period code turns the
    // watchdog off and a reserved window code falls back to normal mode.
    // That is the safe reading for the window, but a user who writes a reserved
    // period code loses protection, which software must avoid.
    function automatic logic [13:0] wwdt_cycles(input logic [3:0] code);
        if (code >= wwdt_pkg::SEL_MIN && code <= wwdt_pkg::SEL_MAX) begin
            wwdt_cycles = wwdt_pkg::SEL_BASE_CYCLES << (code - wwdt_pkg::SEL_MIN);
        end else begin
            wwdt_cycles = 14'h0000;
        end
    endfunction

    // Bus phase decode.
    logic setup_phase;
    logic access_done;
    logic wr_ctrl;
    logic wr_state;
    logic wr_guard;
    logic keyed;

    // Stored state.
    wwdt_pkg::wwdt_ctrl_t ctrl_reg;
    wwdt_pkg::wwdt_ctrl_t act_reg;
    wwdt_pkg::wwdt_state_t state_reg;
    logic [13:0] cnt_reg;
    logic lock_reg;
    logic boot_done_reg;
    logic [2:0] guard_reg;
    logic [DIV_W-1:0] div_reg;
    logic tick;
    logic ctrl_sync_reg;
    logic [1:0] ctrl_ticks_reg;
    logic clr_sync_reg;
    logic [1:0] clr_ticks_reg;
    logic clr_event;
    logic apply_event;
    logic halt_reg;
    logic [13:0] open_len;
    logic [13:0] closed_len;
    logic wdt_on;

    // The slave always answers without wait states and never faults.
    // Refused writes are dropped quietly rather than flagged with an error, so
    // that a stray write from runaway code cannot itself raise a bus fault.
    // The write strobes below are decoded in the access phase only, which is
    // the single edge at which a write may take effect.
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable;
    assign wr_ctrl = access_done && pwrite && paddr == wwdt_pkg::CTRL_ADDR;
    assign wr_state = access_done && pwrite && paddr == wwdt_pkg::STATE_ADDR;
    assign wr_guard = access_done && pwrite && paddr == wwdt_pkg::GUARD_ADDR;
    assign keyed = guard_reg != 3'h0;

    // Read data is captured in the setup phase so it stands during access.
    // Registering the read data keeps prdata free of glitches from the address
    // decode; the cost is that a value changed in the same setup cycle is seen
    // by the next read only. The data then holds until the next setup cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            case (paddr)
                wwdt_pkg::CTRL_ADDR: prdata <= {24'h00_0000, ctrl_reg};
                wwdt_pkg::STATE_ADDR: begin
                    prdata <= 32'h0000_0000;
                    prdata[wwdt_pkg::LOCK_BIT] <= lock_reg;
                    prdata[wwdt_pkg::SYNC_BIT] <= ctrl_sync_reg;
                end
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Change guard: the key opens a window of a few following transfers.
    // Bus transfers stand in for instructions, the nearest thing visible here.
    // Every completed transfer uses one slot, whatever its address, so reads
    // between the key and the protected write shorten the window too.
    // A fresh key write reloads the full window rather than adding to it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_reg <= 3'h0;
        end else if (wr_guard && pwdata[7:0] == wwdt_pkg::IO_UNLOCK_KEY) begin
            guard_reg <= wwdt_pkg::GUARD_WINDOW;
        end else if (access_done && keyed) begin
            guard_reg <= guard_reg - 3'h1;
        end
    end

    // Boot load happens on the first clock after reset release.
    // The fuse value is taken once, at that edge, and never again; the fuse
    // pins may therefore change later without disturbing the settings.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_done_reg <= 1'b0;
        end else begin
            boot_done_reg <= 1'b1;
        end
    end

    // Bus-side control register: fuse at boot, then guarded writes.
    // This copy is what software reads back at once; the counter uses its own
    // copy, which follows only when the crossing has finished.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= wwdt_pkg::CTRL_RESET;
        end else if (!boot_done_reg) begin
            ctrl_reg <= boot_fuse_config;
        end else if (wr_ctrl && keyed && !lock_reg) begin
            ctrl_reg <= pwdata[7:0];
        end
    end

    // Lock bit: set by boot or keyed write, cleared only while halted.
    // Only the lock bit is writable here; the pending flag is built from the
    // crossing logic alone, so a write to this register can never touch it.
    // Once locked, running code cannot turn the watchdog off by any write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= wwdt_pkg::STATE_RESET[wwdt_pkg::LOCK_BIT];
        end else if (!boot_done_reg) begin
            lock_reg <= boot_fuse_config[wwdt_pkg::PERIOD_LSB +: 4] != wwdt_pkg::SEL_OFF;
        end else if (wr_state && keyed) begin
            if (pwdata[wwdt_pkg::LOCK_BIT]) begin
                lock_reg <= 1'b1;
            end else if (debug_halt) begin
                lock_reg <= 1'b0;
            end
        end
    end

    // Divider that makes the 1 kHz watchdog tick as a one-cycle enable.
    // The block has one clock, so the slow watchdog clock is modelled by this
    // enable instead of a second clock domain. The tick phase is not tied to
    // any bus event, which is why every crossing below takes two to three
    // watchdog periods, as a real crossing into a slow clock would.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (div_reg == DIV_W'(TICK_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end
    assign tick = div_reg == DIV_W'(TICK_DIV - 1);

    // Control write crossing: pending until the third tick after the write.
    // A new write restarts the crossing, so the last value always lands.
    // Writing during the crossing is still a software fault, since it delays
    // the new setting by another full crossing time.
    // The set of the pending flag takes priority over its clear in one cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_sync_reg <= wwdt_pkg::STATE_RESET[wwdt_pkg::SYNC_BIT];
            ctrl_ticks_reg <= 2'h0;
        end else if (wr_ctrl && keyed && !lock_reg) begin
            ctrl_sync_reg <= 1'b1;
            ctrl_ticks_reg <= 2'h0;
        end else if (ctrl_sync_reg && tick) begin
            if (ctrl_ticks_reg == wwdt_pkg::SYNC_TICKS - 2'h1) begin
                ctrl_sync_reg <= 1'b0;
                ctrl_ticks_reg <= 2'h0;
            end else begin
                ctrl_ticks_reg <= ctrl_ticks_reg + 2'h1;
            end
        end
    end
    assign apply_event = ctrl_sync_reg && tick && ctrl_ticks_reg == wwdt_pkg::SYNC_TICKS - 2'h1;

    // Watchdog-side copy of the control value, used by the counter.
    // After the boot load it changes only on a tick, so the counter never sees a value half-way
    // through a bus write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_reg <= wwdt_pkg::CTRL_RESET;
        end else if (!boot_done_reg) begin
            act_reg <= boot_fuse_config;
        end else if (apply_event) begin
            act_reg <= ctrl_reg;
        end
    end

    assign open_len = wwdt_cycles(act_reg.period);
    assign closed_len = wwdt_cycles(act_reg.window);
    assign wdt_on = open_len != 14'h0000;

    // Clear crossing: a clear is acted on at the third tick after it.
    // Clears arriving while one is in flight are dropped on purpose.
    // Software that clears in a tight loop therefore sees only one clear per
    // crossing, which keeps a stuck loop from hiding inside the window.
    // A clear while the watchdog is off is ignored rather than stored.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_sync_reg <= 1'b0;
            clr_ticks_reg <= 2'h0;
        end else if (!clr_sync_reg) begin
            if (watchdog_clear_instr && wdt_on && !debug_halt) begin
                clr_sync_reg <= 1'b1;
                clr_ticks_reg <= 2'h0;
            end
        end else if (debug_halt) begin
            clr_sync_reg <= 1'b0;
            clr_ticks_reg <= 2'h0;
        end else if (tick) begin
            if (clr_ticks_reg == wwdt_pkg::SYNC_TICKS - 2'h1) begin
                clr_sync_reg <= 1'b0;
                clr_ticks_reg <= 2'h0;
            end else begin
                clr_ticks_reg <= clr_ticks_reg + 2'h1;
            end
        end
    end
    assign clr_event = clr_sync_reg && tick && !debug_halt && clr_ticks_reg == wwdt_pkg::SYNC_TICKS - 2'h1;

    // Remember halt; the counter does not use this copy to re-arm the first-clear wait.
    // The counter itself is re-armed while halt stands, so leaving halt needs
    // no extra edge logic; this copy is kept for observation only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_reg <= 1'b0;
        end else begin
            halt_reg <= debug_halt;
        end
    end

    // Counter and mode state. No sleep input exists: the tick never stops,
    // so counting and resets continue in every sleep mode.
    // In window mode the first period after enable, halt exit or a reset is a
    // plain time-out; only the first clear starts the closed period, so boot
    // code gets a full period before the window rules apply.
    // Every reset request is one clock wide and the counter returns to zero.
    // A premature clear and a late one both end in the same request, so the
    // reset controller cannot tell them apart; software must keep its own log.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= wwdt_pkg::ST_OFF;
            cnt_reg <= 14'h0000;
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= 1'b0;
            if (!wdt_on) begin
                state_reg <= wwdt_pkg::ST_OFF;
                cnt_reg <= 14'h0000;
            end else if (debug_halt) begin
                cnt_reg <= 14'h0000;
                state_reg <= closed_len != 14'h0000 ? wwdt_pkg::ST_FIRST : wwdt_pkg::ST_OPEN;
            end else if (apply_event || state_reg == wwdt_pkg::ST_OFF) begin
                // Fresh setting: window mode waits for its first clear; a closed period restarts instead.
                cnt_reg <= 14'h0000;
                if (closed_len == 14'h0000) begin
                    state_reg <= wwdt_pkg::ST_OPEN;
                end else if (apply_event && state_reg != wwdt_pkg::ST_OPEN && state_reg != wwdt_pkg::ST_OFF) begin
                    state_reg <= state_reg;
                end else begin
                    state_reg <= wwdt_pkg::ST_FIRST;
                end
            end else begin
                case (state_reg)
                    wwdt_pkg::ST_FIRST: begin
                        // Plain time-out until the first clear opens the cycle.
                        if (clr_event) begin
                            state_reg <= wwdt_pkg::ST_CLOSED;
                            cnt_reg <= 14'h0000;
                        end else if (tick) begin
                            if (cnt_reg + 14'h0001 >= open_len) begin
                                sys_reset_req <= 1'b1;
                                cnt_reg <= 14'h0000;
                            end else begin
                                cnt_reg <= cnt_reg + 14'h0001;
                            end
                        end
                    end
                    wwdt_pkg::ST_CLOSED: begin
                        if (clr_event) begin
                            sys_reset_req <= 1'b1;
                            cnt_reg <= 14'h0000;
                            state_reg <= wwdt_pkg::ST_FIRST;
                        end else if (tick) begin
                            if (cnt_reg + 14'h0001 >= closed_len) begin
                                state_reg <= wwdt_pkg::ST_OPEN;
                                cnt_reg <= 14'h0000;
                            end else begin
                                cnt_reg <= cnt_reg + 14'h0001;
                            end
                        end
                    end
                    wwdt_pkg::ST_OPEN: begin
                        if (clr_event) begin
                            cnt_reg <= 14'h0000;
                            state_reg <= closed_len != 14'h0000 ? wwdt_pkg::ST_CLOSED : wwdt_pkg::ST_OPEN;
                        end else if (tick) begin
                            if (cnt_reg + 14'h0001 >= open_len) begin
                                sys_reset_req <= 1'b1;
                                cnt_reg <= 14'h0000;
                                state_reg <= closed_len != 14'h0000 ? wwdt_pkg::ST_FIRST : wwdt_pkg::ST_OPEN;
                            end else begin
                                cnt_reg <= cnt_reg + 14'h0001;
                            end
                        end
                    end
                    default: begin
                        state_reg <= wwdt_pkg::ST_OFF;
                        cnt_reg <= 14'h0000;
                    end
                endcase
            end
        end
    end

endmodule // wwdt_top

// >>> dv/wwdt_chk.sv
// Port checker for the windowed watchdog timer, bound to its top module.
`timescale 1ns/100ps
module wwdt_chk #(
    parameter int TICK_DIV = 10
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wwdt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core, fuse and reset controller.
    input wire logic watchdog_clear_instr,
    input wire logic debug_halt,
    input wire logic [7:0] boot_fuse_config,
    input wire logic sys_reset_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    int gap;
    // Cycles since reset or the last request; two watchdog ticks must fit in between.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 0;
        end else if (sys_reset_req) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
    sequence rd_access;
        psel && penable && !pwrite;
    endsequence
    sequence access_then_idle;
        psel && penable ##1 !psel;
    endsequence
    ready_no_error_a: assert property (pready && !pslverr) else $error("bus answer faulted");
    reset_single_a: assert property (sys_reset_req |=> !sys_reset_req) else $error("request too long");
    halt_quiet_a: assert property ($past(debug_halt) && debug_halt |-> !sys_reset_req)
        else $error("request during halt");
    reset_gap_a: assert property (sys_reset_req |-> gap >= 2 * TICK_DIV) else $error("request too early");
    rdata_upper_a: assert property (rd_access |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    state_spare_a: assert property (rd_access and paddr == wwdt_pkg::STATE_ADDR |-> prdata[6:1] == 6'h0)
        else $error("spare state bits set");
    unmapped_zero_a: assert property (rd_access and paddr > 12'h00b |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (access_then_idle |-> $stable(prdata)) else $error("read data moved");
endmodule // wwdt_chk

bind wwdt_top wwdt_chk #(.TICK_DIV(TICK_DIV)) i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_clear_instr(watchdog_clear_instr), .debug_halt(debug_halt), .boot_fuse_config(boot_fuse_config),
    .sys_reset_req(sys_reset_req));

// >>> dv/wwdt_core_model.sv
// Processor core and reset controller model: sends clears and counts reset requests.
`timescale 1ns/100ps
module wwdt_core_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Bench command and device side.
    input wire logic clr_cmd,
    input wire logic sys_reset_req,
    output logic watchdog_clear_instr,
    output int rst_seen
);
    // A clear leaves the core one cycle after the bench asks, as a single pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_clear_instr <= 1'b0;
        end else begin
            watchdog_clear_instr <= clr_cmd;
        end
    end
    // Every cycle of request counts, so a stretched pulse shows up as an extra reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_seen <= 0;
        end else if (sys_reset_req === 1'b1) begin
            rst_seen <= rst_seen + 1;
        end
    end
endmodule // wwdt_core_model

// >>> dv/tb_top.sv
// Self-checking testbench for the windowed watchdog timer.
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [wwdt_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic clr_cmd = 1'b0;
    logic debug_halt = 1'b1;
    logic [7:0] boot_fuse_config = 8'h01;
    logic watchdog_clear_instr;
    logic sys_reset_req;
    int rst_seen;
    int base;
    int failures = 0;
    int checks = 0;
    logic [7:0] q;
    // Ten clocks per watchdog tick keeps the time-outs short: code 1 is 80 clocks.
    always #5 clk = ~clk;
    wwdt_top #(.TICK_DIV(10)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdog_clear_instr(watchdog_clear_instr), .debug_halt(debug_halt),
        .boot_fuse_config(boot_fuse_config), .sys_reset_req(sys_reset_req));
    wwdt_core_model i_core (.clk(clk), .rst_n(rst_n), .clr_cmd(clr_cmd), .sys_reset_req(sys_reset_req),
        .watchdog_clear_instr(watchdog_clear_instr), .rst_seen(rst_seen));
    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmp8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cmpn(input string nm, input int exp);
        checks++;
        if (rst_seen - base != exp) begin
            failures++;
            $display("[ERR] %s expected %0d seen %0d", nm, exp, rst_seen - base);
        end
    endtask
    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [wwdt_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                failures++;
                give_verdict();
            end
            @(posedge clk);
        end
        q = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [wwdt_pkg::ADDR_W-1:0] a);
        apb(1'b0, a, 8'h00);
    endtask
    task automatic kwr(input logic [wwdt_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        apb(1'b1, wwdt_pkg::GUARD_ADDR, wwdt_pkg::IO_UNLOCK_KEY);
        apb(1'b1, a, d);
    endtask
    task automatic clear();
        @(posedge clk);
        clr_cmd <= 1'b1;
        @(posedge clk);
        clr_cmd <= 1'b0;
    endtask
    // Polls the pending flag so that no control write lands mid-crossing.
    task automatic wait_sync();
        int n;
        n = 0;
        do begin
            rd(wwdt_pkg::STATE_ADDR);
            n++;
            if (n > 20) begin
                failures++;
                give_verdict();
            end
        end while (q[0] !== 1'b0);
    endtask
    task automatic t_boot();
        rd(wwdt_pkg::CTRL_ADDR);
        cmp8("watchdog_control", 8'h01, q);
        rd(wwdt_pkg::STATE_ADDR);
        cmp8("watchdog_state", 8'h80, q);
        kwr(wwdt_pkg::CTRL_ADDR, 8'h00);
        rd(wwdt_pkg::CTRL_ADDR);
        cmp8("watchdog_control", 8'h01, q);
        kwr(wwdt_pkg::STATE_ADDR, 8'h00);
        rd(wwdt_pkg::STATE_ADDR);
        cmp8("watchdog_state", 8'h00, q);
        base = rst_seen;
        repeat (200) @(posedge clk);
        cmpn("halted resets", 0);
        kwr(wwdt_pkg::CTRL_ADDR, 8'h00);
        wait_sync();
        debug_halt <= 1'b0;
    endtask
    task automatic t_guard();
        apb(1'b1, wwdt_pkg::CTRL_ADDR, 8'h05);
        apb(1'b1, wwdt_pkg::STATE_ADDR, 8'h81);
        rd(wwdt_pkg::CTRL_ADDR);
        cmp8("watchdog_control", 8'h00, q);
        rd(wwdt_pkg::STATE_ADDR);
        cmp8("watchdog_state", 8'h00, q);
        apb(1'b1, wwdt_pkg::GUARD_ADDR, wwdt_pkg::IO_UNLOCK_KEY);
        repeat (4) rd(wwdt_pkg::STATE_ADDR);
        apb(1'b1, wwdt_pkg::CTRL_ADDR, 8'h05);
        rd(wwdt_pkg::CTRL_ADDR);
        cmp8("watchdog_control", 8'h00, q);
        apb(1'b1, wwdt_pkg::GUARD_ADDR, wwdt_pkg::IO_UNLOCK_KEY);
        repeat (3) rd(wwdt_pkg::STATE_ADDR);
        apb(1'b1, wwdt_pkg::CTRL_ADDR, 8'h10);
        wait_sync();
        rd(wwdt_pkg::CTRL_ADDR);
        cmp8("watchdog_control", 8'h10, q);
        base = rst_seen;
        repeat (200) @(posedge clk);
        cmpn("disabled resets", 0);
        rd(12'h010);
        cmp8("unmapped", 8'h00, q);
    endtask
    task automatic t_normal();
        kwr(wwdt_pkg::CTRL_ADDR, 8'h01);
        rd(wwdt_pkg::STATE_ADDR);
        cmp8("sync_pending_flag", 8'h01, q);
        wait_sync();
        base = rst_seen;
        repeat (100) @(posedge clk);
        cmpn("time-out resets", 1);
        base = rst_seen;
        repeat (10) begin
            clear();
            repeat (38) @(posedge clk);
        end
        cmpn("serviced resets", 0);
        kwr(wwdt_pkg::CTRL_ADDR, 8'h00);
        wait_sync();
    endtask
    task automatic t_window();
        kwr(wwdt_pkg::CTRL_ADDR, 8'h11);
        wait_sync();
        repeat (10) @(posedge clk);
        base = rst_seen;
        clear();
        repeat (50) @(posedge clk);
        clear();
        repeat (60) @(posedge clk);
        cmpn("early clear resets", 1);
        repeat (10) @(posedge clk);
        base = rst_seen;
        clear();
        repeat (128) @(posedge clk);
        clear();
        repeat (118) @(posedge clk);
        cmpn("open clear resets", 0);
        repeat (110) @(posedge clk);
        cmpn("late open resets", 1);
    endtask
    task automatic t_lock();
        kwr(wwdt_pkg::STATE_ADDR, 8'h80);
        kwr(wwdt_pkg::CTRL_ADDR, 8'h00);
        kwr(wwdt_pkg::STATE_ADDR, 8'h00);
        rd(wwdt_pkg::CTRL_ADDR);
        cmp8("watchdog_control", 8'h11, q);
        rd(wwdt_pkg::STATE_ADDR);
        cmp8("watchdog_state", 8'h80, q);
    endtask
    // Reset is held for sixteen clocks; the first transfer starts three edges after release.
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_boot();
        t_guard();
        t_normal();
        t_window();
        t_lock();
        give_verdict();
    end
endmodule // tb_top
